// ### hdl/ssio_pkg.sv
package ssio_pkg;

  // Register word offsets (byte addresses on the APB side)
  localparam logic [11:0] SSIO_MODE_OFF   = 12'h000;
  localparam logic [11:0] SSIO_DATA_OFF   = 12'h004;
  localparam logic [11:0] SSIO_PWR_OFF    = 12'h008;

  // Mode register field positions
  localparam int SSIO_DONE_BIT  = 7;
  localparam int SSIO_IEN_BIT   = 6;
  localparam int SSIO_CKE_BIT   = 5;
  localparam int SSIO_TXE_BIT   = 4;
  localparam int SSIO_CKS_HI    = 3;
  localparam int SSIO_CKS_LO    = 2;
  localparam int SSIO_ORDER_BIT = 1;
  localparam int SSIO_GO_BIT    = 0;

  // Power register field positions
  localparam int SSIO_SLEEP_BIT = 0;
  localparam int SSIO_STOP_BIT  = 1;

  localparam logic [7:0] SSIO_MODE_RST = 8'h00;
  localparam logic [7:0] SSIO_DATA_RST = 8'h00;
  localparam logic [1:0] SSIO_CKS_EXT  = 2'h3;
  localparam logic [3:0] SSIO_BITS     = 4'h8;

  // Internal shift clock half periods in system clocks, per select code
  localparam int SSIO_CLK_NS   = 50;
  localparam int SSIO_HALF0_NS = 200;
  localparam int SSIO_HALF1_NS = 800;
  localparam int SSIO_HALF2_NS = 3200;
  localparam logic [7:0] SSIO_HALF0 = 8'((SSIO_HALF0_NS + SSIO_CLK_NS - 1)
                                         / SSIO_CLK_NS);
  localparam logic [7:0] SSIO_HALF1 = 8'((SSIO_HALF1_NS + SSIO_CLK_NS - 1)
                                         / SSIO_CLK_NS);
  localparam logic [7:0] SSIO_HALF2 = 8'((SSIO_HALF2_NS + SSIO_CLK_NS - 1)
                                         / SSIO_CLK_NS);

  // Half period for an internal select code
  function automatic logic [7:0] ssio_half(input logic [1:0] cks);
    case (cks)
      2'h0:    ssio_half = SSIO_HALF0;
      2'h1:    ssio_half = SSIO_HALF1;
      default: ssio_half = SSIO_HALF2;
    endcase
  endfunction

endpackage

// ### hdl/ssio_link_if.sv
`timescale 1ns/1ps
`default_nettype none
interface ssio_link_if;
  logic sck_a_o;
  logic sck_a_oe;
  logic sd_a_o;
  logic sd_a_oe;
  logic sck_b_o;
  logic sck_b_oe;
  logic sd_b_o;
  logic sd_b_oe;
  logic sck;
  logic sd_ab;
  logic sd_ba;

  // Shift clock is pulled high when nobody drives it
  assign sck   = sck_a_oe ? sck_a_o : (sck_b_oe ? sck_b_o : 1'b1);
  assign sd_ab = sd_a_oe ? sd_a_o : 1'b1;
  assign sd_ba = sd_b_oe ? sd_b_o : 1'b1;

  modport dev (
    output sck_a_o, sck_a_oe, sd_a_o, sd_a_oe,
    input  sck, sd_ba
  );
  modport partner (
    output sck_b_o, sck_b_oe, sd_b_o, sd_b_oe,
    input  sck, sd_ab
  );
endinterface
`default_nettype wire

// ### hdl/ssio_dev.sv
`timescale 1ns/1ps
`default_nettype none
module ssio_dev
  import ssio_pkg::*;
(
  // System
  input  wire logic        clk,
  input  wire logic        arst_n,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // Interrupt request
  output logic             irq,
  // Link
  ssio_link_if.dev         link
);

  typedef struct packed {
    logic [7:0] mode;
    logic [7:0] shift;
    logic [1:0] pwr;
    logic [3:0] bitcnt;
    logic [7:0] div;
    logic       sck_int;
    logic       sck_m1;
    logic       sck_m2;
    logic       sck_m3;
    logic       sd_m1;
    logic       sd_m2;
    logic       sd_out;
    logic       stray;
    logic [31:0] rdata;
  } ssio_dev_t;

  ssio_dev_t s_q;
  ssio_dev_t s_d;

  logic       acc;
  logic       wr;
  logic       ext;
  logic       go;
  logic       rise;
  logic       fall;
  logic       halted;
  logic [7:0] wmode;

  always_comb begin
    acc    = psel & penable;
    wr     = acc & pwrite;
    ext    = {s_q.mode[SSIO_CKS_HI], s_q.mode[SSIO_CKS_LO]} == SSIO_CKS_EXT;
    go     = s_q.mode[SSIO_GO_BIT];
    halted = s_q.pwr[SSIO_STOP_BIT];
    wmode  = pwdata[7:0];
    s_d    = s_q;
    s_d.sck_m1 = link.sck;
    s_d.sck_m2 = s_q.sck_m1;
    s_d.sck_m3 = s_q.sck_m2;
    s_d.sd_m1  = link.sd_ba;
    s_d.sd_m2  = s_q.sd_m1;
    // ---------------------------------------------------------------
    // Shift clock source
    // ---------------------------------------------------------------
    rise = 1'b0;
    fall = 1'b0;
    if (ext) begin
      s_d.sck_int = 1'b1;
      rise = s_q.sck_m2 & ~s_q.sck_m3;
      fall = ~s_q.sck_m2 & s_q.sck_m3;
    end else if (go && !halted) begin
      if (s_q.div == 8'h00) begin
        s_d.div     = ssio_half({s_q.mode[SSIO_CKS_HI],
                                 s_q.mode[SSIO_CKS_LO]}) - 8'h01;
        s_d.sck_int = ~s_q.sck_int;
        rise = ~s_q.sck_int;
        fall = s_q.sck_int;
      end else begin
        s_d.div = s_q.div - 8'h01;
      end
    end else begin
      s_d.sck_int = 1'b1;
      s_d.div     = 8'h00;
    end
    // ---------------------------------------------------------------
    // Shifter
    // ---------------------------------------------------------------
    if (halted) begin
      s_d.mode[SSIO_GO_BIT] = 1'b0;
      s_d.bitcnt = 4'h0;
    end else begin
      if (fall && (go || ext)) begin
        // Output moves even when aborted in external mode
        s_d.sd_out = s_q.mode[SSIO_ORDER_BIT] ? s_q.shift[7]
                                              : s_q.shift[0];
        s_d.stray  = 1'b0;
      end
      // Held off after a rise, so only a mode or data write moves the pin while the clock is high
      if (!fall && !go && ext && !s_q.stray) begin
        s_d.sd_out = s_q.mode[SSIO_ORDER_BIT] ? s_q.shift[7]
                                              : s_q.shift[0];
      end
      // External rises after an abort still shift the buffer
      if (rise && (go || ext)) begin
        s_d.shift = s_q.mode[SSIO_ORDER_BIT] ? {s_q.shift[6:0], s_q.sd_m2}
                                             : {s_q.sd_m2, s_q.shift[7:1]};
        s_d.stray = ext;
      end
      if (rise && go) begin
        s_d.bitcnt = s_q.bitcnt + 4'h1;
        if (s_q.bitcnt + 4'h1 == SSIO_BITS) begin
          s_d.bitcnt = 4'h0;
          s_d.mode[SSIO_GO_BIT]   = 1'b0;
          s_d.mode[SSIO_DONE_BIT] = 1'b1;
          // A go clear written in the same cycle wins
          if (wr && paddr == SSIO_MODE_OFF && !wmode[SSIO_GO_BIT]) begin
            s_d.mode[SSIO_DONE_BIT] = s_q.mode[SSIO_DONE_BIT];
          end
        end
      end
    end
    // ---------------------------------------------------------------
    // Register writes
    // ---------------------------------------------------------------
    if (wr) begin
      unique case (paddr)
        SSIO_MODE_OFF: begin
          s_d.mode[6:1] = wmode[6:1];
          s_d.stray     = 1'b0;
          // Writing one to done is ignored, and a new done wins
          if (!wmode[SSIO_DONE_BIT] && !(s_d.mode[SSIO_DONE_BIT] &&
              !s_q.mode[SSIO_DONE_BIT])) begin
            s_d.mode[SSIO_DONE_BIT] = 1'b0;
          end
          if (!wmode[SSIO_GO_BIT]) begin
            s_d.mode[SSIO_GO_BIT] = 1'b0;
            s_d.bitcnt = 4'h0;
          end else if (!go && !halted) begin
            s_d.mode[SSIO_GO_BIT] = 1'b1;
            s_d.bitcnt = 4'h0;
          end
        end
        SSIO_DATA_OFF: begin
          s_d.shift = pwdata[7:0];
          s_d.stray = 1'b0;
        end
        SSIO_PWR_OFF:  s_d.pwr   = pwdata[1:0];
        default: ;
      endcase
    end
    unique case (paddr)
      SSIO_MODE_OFF: s_d.rdata = {24'h0, s_q.mode};
      SSIO_DATA_OFF: s_d.rdata = {24'h0, s_q.shift};
      SSIO_PWR_OFF:  s_d.rdata = {30'h0, s_q.pwr};
      default:       s_d.rdata = 32'h0;
    endcase
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      s_q <= '{mode: SSIO_MODE_RST, shift: SSIO_DATA_RST, pwr: 2'h0,
               bitcnt: 4'h0, div: 8'h00, sck_int: 1'b1, sck_m1: 1'b1,
               sck_m2: 1'b1, sck_m3: 1'b1, sd_m1: 1'b1, sd_m2: 1'b1,
               sd_out: 1'b1, stray: 1'b0, rdata: 32'h0};
    end else begin
      s_q <= s_d;
    end
  end

  // Read data is registered in the setup cycle and shown in the access
  assign prdata  = s_q.rdata;
  assign pready  = 1'b1;
  assign pslverr = acc & (paddr != SSIO_MODE_OFF) & (paddr != SSIO_DATA_OFF)
                   & (paddr != SSIO_PWR_OFF);
  assign irq     = s_q.mode[SSIO_DONE_BIT] & s_q.mode[SSIO_IEN_BIT];

  assign link.sck_a_o  = s_q.sck_int;
  assign link.sck_a_oe = s_q.mode[SSIO_CKE_BIT] & ~ext;
  assign link.sd_a_o   = s_q.sd_out;
  assign link.sd_a_oe  = s_q.mode[SSIO_TXE_BIT];

endmodule // ssio_dev
`default_nettype wire

// ### hdl/ssio_partner.sv
`timescale 1ns/1ps
`default_nettype none
module ssio_partner
  import ssio_pkg::*;
(
  // System
  input  wire logic       clk,
  input  wire logic       arst_n,
  // User side
  input  wire logic       start,
  input  wire logic       drive_clk,
  input  wire logic       msb_first,
  input  wire logic [7:0] tx_byte,
  output logic            busy,
  output logic            done,
  output logic      [7:0] rx_byte,
  // Link
  ssio_link_if.partner    link
);

  typedef enum logic [1:0] {
    PS_IDLE  = 2'b00,
    PS_ARMED = 2'b01,
    PS_DRIVE = 2'b10
  } ssio_pst_t;

  typedef struct packed {
    ssio_pst_t  st;
    logic [7:0] shift;
    logic [3:0] bitcnt;
    logic [7:0] div;
    logic       sck;
    logic       msb;
    logic       sd_out;
    logic       done;
    logic [7:0] rx;
    logic       ck1, ck2, ck3, d1, d2;
  } ssio_part_t;

  ssio_part_t p_q;
  ssio_part_t p_d;
  logic       rise;
  logic       fall;

  always_comb begin
    p_d      = p_q;
    p_d.done = 1'b0;
    p_d.ck1  = link.sck;
    p_d.ck2  = p_q.ck1;
    p_d.ck3  = p_q.ck2;
    p_d.d1   = link.sd_ab;
    p_d.d2   = p_q.d1;
    rise = p_q.ck2 & ~p_q.ck3;
    fall = ~p_q.ck2 & p_q.ck3;
    unique case (p_q.st)
      PS_IDLE: begin
        p_d.sck = 1'b1;
        if (start) begin
          p_d.shift  = tx_byte;
          p_d.msb    = msb_first;
          p_d.bitcnt = 4'h0;
          p_d.sd_out = msb_first ? tx_byte[7] : tx_byte[0];
          p_d.div    = SSIO_HALF2;
          p_d.st     = drive_clk ? PS_DRIVE : PS_ARMED;
        end
      end
      PS_DRIVE: begin
        rise = 1'b0;
        fall = 1'b0;
        if (p_q.div == 8'h00) begin
          p_d.div = SSIO_HALF2 - 8'h01;
          p_d.sck = ~p_q.sck;
          rise    = ~p_q.sck;
          fall    = p_q.sck;
        end else begin
          p_d.div = p_q.div - 8'h01;
        end
      end
      default: ;
    endcase
    if (p_q.st != PS_IDLE) begin
      if (fall) begin
        p_d.sd_out = p_q.msb ? p_q.shift[7] : p_q.shift[0];
      end
      if (rise) begin
        p_d.shift  = p_q.msb ? {p_q.shift[6:0], p_q.d2}
                             : {p_q.d2, p_q.shift[7:1]};
        p_d.bitcnt = p_q.bitcnt + 4'h1;
        if (p_q.bitcnt + 4'h1 == SSIO_BITS) begin
          p_d.rx   = p_d.shift;
          p_d.done = 1'b1;
          p_d.sck  = 1'b1;
          p_d.st   = PS_IDLE;
        end
      end
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      p_q <= '{st: PS_IDLE, shift: 8'h00, bitcnt: 4'h0, div: 8'h00,
               sck: 1'b1, msb: 1'b0, sd_out: 1'b1, done: 1'b0,
               rx: 8'h00, ck1: 1'b1, ck2: 1'b1, ck3: 1'b1, d1: 1'b1,
               d2: 1'b1};
    end else begin
      p_q <= p_d;
    end
  end

  assign busy          = p_q.st != PS_IDLE;
  assign done          = p_q.done;
  assign rx_byte       = p_q.rx;
  assign link.sck_b_o  = p_q.sck;
  assign link.sck_b_oe = p_q.st == PS_DRIVE;
  assign link.sd_b_o   = p_q.sd_out;
  assign link.sd_b_oe  = 1'b1;

endmodule // ssio_partner
`default_nettype wire

// ### verif/ssio_link_chk.sv
`timescale 1ns/1ps
`default_nettype none
module ssio_burst_cnt (
  input  wire logic       clk,
  input  wire logic       arst_n,
  input  wire logic       c,
  input  wire logic       oe,
  output logic      [3:0] n_q
);
  logic [6:0] hi_q;
  logic       c_q;
  // A high spell of 90 clocks ends a burst; no half period is that long
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      n_q  <= 4'h0;
      hi_q <= 7'h00;
      c_q  <= 1'b1;
    end else begin
      c_q  <= c;
      hi_q <= !c ? 7'h00 : (hi_q == 7'h64 ? hi_q : hi_q + 7'h01);
      if (hi_q == 7'h5a) n_q <= 4'h0;
      else if (oe && c_q && !c) n_q <= n_q + 4'h1;
    end
  end
endmodule // ssio_burst_cnt

module ssio_link_chk (
  // System
  input  wire logic clk,
  input  wire logic arst_n,
  // Link
  input  wire logic sck_a_o,
  input  wire logic sck_a_oe,
  input  wire logic sck_b_o,
  input  wire logic sck_b_oe,
  input  wire logic sck,
  input  wire logic sd_ab,
  input  wire logic sd_ba
);
  logic [3:0] n_a;
  logic [3:0] n_b;
  ssio_burst_cnt u_a (.clk(clk), .arst_n(arst_n), .c(sck_a_o),
                      .oe(sck_a_oe), .n_q(n_a));
  ssio_burst_cnt u_b (.clk(clk), .arst_n(arst_n), .c(sck_b_o),
                      .oe(sck_b_oe), .n_q(n_b));
  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);
  property p_tx_int;
    $changed(sd_ab) && sck_a_oe && $past(sck_a_oe) |-> !sck_a_o;
  endproperty
  a_tx_int: assert property (p_tx_int)
    else $error("tx moved while own clock high");
  property p_tx_ext;
    $changed(sd_ab) && sck_b_oe && $past(sck_b_oe) |-> !sck;
  endproperty
  a_tx_ext: assert property (p_tx_ext)
    else $error("tx moved while far clock high");
  property p_rx_stable;
    $rose(sck_a_o) && sck_a_oe |-> $stable(sd_ba);
  endproperty
  a_rx_stable: assert property (p_rx_stable)
    else $error("rx line moved at sample");
  property p_int_idle;
    sck_a_oe && $fell(sck_a_o) |-> ##[1:64] sck_a_o;
  endproperty
  a_int_idle: assert property (p_int_idle)
    else $error("driven clock stuck low");
  property p_ext_idle;
    sck_b_oe && $fell(sck_b_o) |-> ##[1:70] sck_b_o;
  endproperty
  a_ext_idle: assert property (p_ext_idle)
    else $error("far clock stuck low");
  property p_int_bits;
    n_a <= 4'h8;
  endproperty
  a_int_bits: assert property (p_int_bits)
    else $error("more than eight driven clocks");
  property p_ext_bits;
    n_b <= 4'h8;
  endproperty
  a_ext_bits: assert property (p_ext_bits)
    else $error("more than eight far clocks");
  property p_ext_low;
    sck_b_oe && $fell(sck_b_o) |-> !sck_b_o [*8];
  endproperty
  a_ext_low: assert property (p_ext_low)
    else $error("far clock low phase short");
  c_int: cover property (n_a == 4'h8);
  c_ext: cover property (n_b == 4'h8);
  c_rx: cover property ($rose(sck_a_o) && sck_a_oe);
endmodule // ssio_link_chk
`default_nettype wire

// ### verif/test_sync_serial_shift_io.sv
`timescale 1ns/1ps
`default_nettype none
module test_sync_serial_shift_io;
  import ssio_pkg::*;
  logic        clk = 1'b0, arst_n = 1'b0, psel = 1'b0, penable = 1'b0;
  logic        pwrite = 1'b0, pready, pslverr, perr, irq, so_q;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic        p_start = 1'b0, p_drv = 1'b0, p_msb = 1'b0, p_busy, p_done;
  logic [7:0]  p_tx = 8'h00, p_rx;
  int          err_count = 0, check_count = 0, cyc = 0, moves = 0;
`define CHK(n, e, s) begin check_count++; if ((s) !== (e)) begin \
  err_count++; $display("Error %s: expected %h seen %h", n, e, s); end end
  always #25 clk = ~clk;
  ssio_link_if ssio_link_if_inst ();
  ssio_dev ssio_dev_inst (.clk(clk), .arst_n(arst_n), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .irq(irq),
    .link(ssio_link_if_inst.dev));
  ssio_partner ssio_partner_inst (.clk(clk), .arst_n(arst_n),
    .start(p_start), .drive_clk(p_drv), .msb_first(p_msb), .tx_byte(p_tx),
    .busy(p_busy), .done(p_done), .rx_byte(p_rx),
    .link(ssio_link_if_inst.partner));
  ssio_link_chk ssio_link_chk_inst (.clk(clk), .arst_n(arst_n),
    .sck_a_o(ssio_link_if_inst.sck_a_o), .sck_a_oe(ssio_link_if_inst.sck_a_oe),
    .sck_b_o(ssio_link_if_inst.sck_b_o), .sck_b_oe(ssio_link_if_inst.sck_b_oe),
    .sck(ssio_link_if_inst.sck), .sd_ab(ssio_link_if_inst.sd_ab),
    .sd_ba(ssio_link_if_inst.sd_ba));
  // ---------------------------------------------------------------
  // Bus and link tasks
  // ---------------------------------------------------------------
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask
  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [7:0] d);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h0, d};
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    rd = prdata;
    perr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic pulse;
    @(posedge clk);
    p_start <= 1'b1;
    @(posedge clk);
    p_start <= 1'b0;
  endtask
  // Far end is armed before a driven clock starts, as it cannot be polled
  task automatic run(input logic [7:0] cfg, d, pd, input logic drv);
    tick(100);
    apb(1'b1, SSIO_MODE_OFF, 8'h00);
    apb(1'b1, SSIO_DATA_OFF, d);
    p_tx <= pd;
    p_msb <= cfg[1];
    p_drv <= drv;
    if (!drv) pulse();
    apb(1'b1, SSIO_MODE_OFF, cfg);
    apb(1'b1, SSIO_MODE_OFF, cfg | 8'h01);
    if (drv) begin
      tick(4);
      `CHK("first bit", cfg[1] ? d[7] : d[0], ssio_link_if_inst.sd_ab)
      pulse();
    end
    for (int i = 0; i < 3000 && p_done !== 1'b1; i++) @(posedge clk);
    tick(10);
    apb(1'b0, SSIO_DATA_OFF, 8'h00);
    `CHK("dev rx", pd, rd[7:0])
    `CHK("partner rx", d, p_rx)
    `CHK("partner idle", 1'b0, p_busy)
    apb(1'b0, SSIO_MODE_OFF, 8'h00);
    `CHK("mode", cfg | 8'h80, rd[7:0])
    $display("transfer test done");
  endtask
  task automatic final_report;
    $display("Checks %0d, errors %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  always @(posedge clk) begin
    cyc++;
    if (cyc == 40000) begin
      err_count++;
      final_report();
    end
  end
  // ---------------------------------------------------------------
  // Test sequence
  // ---------------------------------------------------------------
  initial begin
    tick(8);
    arst_n <= 1'b1;
    apb(1'b1, SSIO_DATA_OFF, 8'h3c);
    apb(1'b1, SSIO_MODE_OFF, 8'h38);
    apb(1'b1, SSIO_MODE_OFF, 8'h39);
    tick(100);
    apb(1'b1, SSIO_MODE_OFF, 8'h38);
    tick(200);
    apb(1'b0, SSIO_MODE_OFF, 8'h00);
    `CHK("abort", 8'h38, rd[7:0])
    apb(1'b1, SSIO_MODE_OFF, 8'h39);
    tick(100);
    apb(1'b1, SSIO_PWR_OFF, 8'h02);
    tick(200);
    apb(1'b0, SSIO_MODE_OFF, 8'h00);
    `CHK("stop", 8'h38, rd[7:0])
    apb(1'b1, SSIO_PWR_OFF, 8'h00);
    apb(1'b0, 12'h00c, 8'h00);
    `CHK("unmapped err", 1'b1, perr)
    `CHK("unmapped data", 32'h0, rd)
    $display("abort and unmapped test done");
    // The fastest rate leaves no room for the far end's synchroniser
    run(8'h76, 8'ha5, 8'h3c, 1'b0);
    `CHK("irq", 1'b1, irq)
    `CHK("idle clock", 1'b1, ssio_link_if_inst.sck)
    apb(1'b1, SSIO_MODE_OFF, 8'hf2);
    apb(1'b0, SSIO_MODE_OFF, 8'h00);
    `CHK("done kept", 8'hf2, rd[7:0])
    apb(1'b1, SSIO_MODE_OFF, 8'h72);
    apb(1'b0, SSIO_MODE_OFF, 8'h00);
    `CHK("done clr", 8'h72, rd[7:0])
    `CHK("irq off", 1'b0, irq)
    apb(1'b1, SSIO_PWR_OFF, 8'h01);
    run(8'h34, 8'h96, 8'h81, 1'b0);
    `CHK("irq masked", 1'b0, irq)
    apb(1'b1, SSIO_PWR_OFF, 8'h00);
    run(8'h1e, 8'h5a, 8'hc3, 1'b1);
    tick(100);
    apb(1'b1, SSIO_DATA_OFF, 8'h0f);
    p_tx <= 8'h55;
    apb(1'b1, SSIO_MODE_OFF, 8'h1e);
    apb(1'b1, SSIO_MODE_OFF, 8'h1f);
    pulse();
    tick(300);
    apb(1'b1, SSIO_MODE_OFF, 8'h1e);
    so_q = ssio_link_if_inst.sd_ab;
    for (int i = 0; i < 3000 && p_done !== 1'b1; i++) begin
      @(posedge clk);
      if (ssio_link_if_inst.sd_ab !== so_q) moves++;
      so_q = ssio_link_if_inst.sd_ab;
    end
    tick(10);
    `CHK("stray clock moves out", 1'b1, moves > 0)
    apb(1'b0, SSIO_MODE_OFF, 8'h00);
    `CHK("no done after abort", 8'h1e, rd[7:0])
    $display("external abort test done");
    final_report();
  end
endmodule // test_sync_serial_shift_io
`default_nettype wire
